// [design/vc1_cap_regs.vh]
// Offsets, field positions, reset values and bus codes for the VC1 capability word
`ifndef VC1_CAP_REGS_VH
`define VC1_CAP_REGS_VH

// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
`define VC1_RESOURCE_CAPABILITY_OFS 12'h15c
`define VC1_RESOURCE_CONTROL_OFS 12'h160
`define VC_PRESENT_OFS 12'h144
`define VC1_EEPROM_SLOTS_OFS 12'h170

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define ARB_CAP_LSB 0
`define ARB_CAP_MSB 7
`define AS_ONLY_BIT 14
`define SNOOP_REJ_BIT 15
`define MAX_SLOTS_LSB 16
`define MAX_SLOTS_MSB 22
`define TABLE_OFS_LSB 24
`define TABLE_OFS_MSB 31
`define VC_PRESENT_BIT 0
`define SLOTS_LOAD_BIT 31

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define ARB_CAP_ON 8'h19
`define ARB_CAP_OFF 8'h00
`define MAX_SLOTS_ON 7'h7f
`define MAX_SLOTS_OFF 7'h00
`define TABLE_OFS_ON 8'h08
`define TABLE_OFS_OFF 8'h00
`define AS_ONLY_RST 1'b0
`define SNOOP_REJ_RST 1'b0
`define VC_PRESENT_RST 1'b0
`define CTRL_RST 32'h0000_0000

// ------------------------------------------------------------
// AXI responses
// ------------------------------------------------------------
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// [design/vc1_cap_word.v]
// Builds the VC1 capability word from the present flag and slot override
`timescale 1ns/1ps
module vc1_cap_word (
    // Presence and override
    input wire vc_present,
    input wire slots_ovr_valid,
    input wire [6:0] slots_ovr,
    // Result
    output wire [31:0] cap_word
);
`include "vc1_cap_regs.vh"

    wire [7:0] arb_cap;
    wire [6:0] max_slots;
    wire [7:0] table_ofs;

    // Schemes 19h: fixed, WRR128, time-based WRR128 (VC1 only)
    assign arb_cap = vc_present ? `ARB_CAP_ON : `ARB_CAP_OFF;
    // EEPROM-style override wins only while VC1 is present
    assign max_slots = !vc_present ? `MAX_SLOTS_OFF :
        (slots_ovr_valid ? slots_ovr : `MAX_SLOTS_ON);
    // Offset counted in sixteen_byte_unit steps
    assign table_ofs = vc_present ? `TABLE_OFS_ON : `TABLE_OFS_OFF;

    assign cap_word = {table_ofs, 1'b0, max_slots,
        `SNOOP_REJ_RST, `AS_ONLY_RST, 6'h00, arb_cap};

endmodule // vc1_cap_word

// [design/axil_resp_hold.v]
// Holds one AXI4-Lite response until the master takes it
`timescale 1ns/1ps
module axil_resp_hold #(
    parameter W = 34
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Load side
    input wire load,
    input wire [W-1:0] load_data,
    // Response side
    output reg valid_q,
    input wire ready,
    output reg [W-1:0] data_q
);

    always @(posedge aclk) begin
        if (!aresetn) begin
            valid_q <= 1'b0;
            data_q <= {W{1'b0}};
        end else if (load) begin
            valid_q <= 1'b1;
            data_q <= load_data;
        end else if (ready) begin
            valid_q <= 1'b0;
        end
    end

endmodule // axil_resp_hold

// [design/vc1_cap_bank.v]
// AXI4-Lite register bank holding the VC1 resource capability word
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// ------------------------------------------------------------
// Overview of operation
// ------------------------------------------------------------
module vc1_cap_bank (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Write address
    input wire [11:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // Write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // Write response
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    // Read address
    input wire [11:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // Read data
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    // Block state
    output reg vc1_present_q,
    output reg [31:0] vc1_control_q
);
`include "vc1_cap_regs.vh"

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    localparam A_CAP = 3'b001;
    localparam A_CTRL = 3'b010;
    localparam A_PRES = 3'b100;
    localparam A_SLOT = 3'b000;

    function [2:0] decode;
        input [11:0] addr;
        begin
            case ({addr[11:2], 2'b00})
                `VC1_RESOURCE_CAPABILITY_OFS: decode = A_CAP;
                `VC1_RESOURCE_CONTROL_OFS: decode = A_CTRL;
                `VC_PRESENT_OFS: decode = A_PRES;
                default: decode = A_SLOT;
            endcase
        end
    endfunction

    function mapped;
        input [11:0] addr;
        begin
            mapped = (decode(addr) != A_SLOT) ||
                ({addr[11:2], 2'b00} == `VC1_EEPROM_SLOTS_OFS);
        end
    endfunction

    function [31:0] merge;
        input [31:0] old;
        input [31:0] wd;
        input [3:0] st;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (st[i]) begin
                    merge[i*8 +: 8] = wd[i*8 +: 8];
                end
            end
        end
    endfunction

    // ------------------------------------------------------------
    // Write channel capture
    // ------------------------------------------------------------
    reg aw_held_q;
    reg [11:0] aw_addr_q;
    reg w_held_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    reg present_next_q;
    reg [6:0] slots_ovr_q;
    reg slots_ovr_valid_q;
    wire bvalid_w;
    wire rvalid_w;
    wire do_write;
    wire [11:0] wr_addr;
    wire [31:0] wr_data;
    wire [3:0] wr_strb;
    wire [31:0] cap_word;
    wire [31:0] slot_reg;
    reg [31:0] rd_mux;

    // Only one write in flight: stall both channels while a response waits
    assign s_axi_awready = !aw_held_q && !bvalid_w;
    assign s_axi_wready = !w_held_q && !bvalid_w;

    assign wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
    assign wr_data = w_held_q ? w_data_q : s_axi_wdata;
    assign wr_strb = w_held_q ? w_strb_q : s_axi_wstrb;
    assign do_write = (aw_held_q || (s_axi_awvalid && s_axi_awready)) &&
        (w_held_q || (s_axi_wvalid && s_axi_wready));

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 12'h000;
            w_held_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (do_write) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Software may change the present bit, but the capability fields
    // follow it only at a next reset lasting one clock (a longer one clears the bit), so a read of the present bit can disagree with them.
    always @(posedge aclk) begin
        if (!aresetn) begin
            present_next_q <= `VC_PRESENT_RST;
            vc1_control_q <= `CTRL_RST;
            slots_ovr_q <= `MAX_SLOTS_OFF;
            slots_ovr_valid_q <= 1'b0;
        end else if (do_write) begin
            case (decode(wr_addr))
                A_PRES: begin
                    if (wr_strb[0]) begin
                        present_next_q <= wr_data[`VC_PRESENT_BIT];
                    end
                end
                A_CTRL: begin
                    vc1_control_q <= merge(vc1_control_q, wr_data, wr_strb);
                end
                A_CAP: begin
                    // Read-only word: writes are dropped
                end
                default: begin
                    if ({wr_addr[11:2], 2'b00} == `VC1_EEPROM_SLOTS_OFS) begin
                        if (wr_strb[0]) begin
                            slots_ovr_q <= wr_data[6:0];
                        end
                        if (wr_strb[3]) begin
                            slots_ovr_valid_q <= wr_data[`SLOTS_LOAD_BIT];
                        end
                    end
                end
            endcase
        end
    end

    // Strap caught on a clock edge while reset is held, no async path
    always @(posedge aclk) begin
        if (!aresetn) begin
            vc1_present_q <= present_next_q;
        end
    end

    vc1_cap_word u_cap (
        .vc_present(vc1_present_q),
        .slots_ovr_valid(slots_ovr_valid_q),
        .slots_ovr(slots_ovr_q),
        .cap_word(cap_word)
    );

    assign slot_reg = {slots_ovr_valid_q, 24'h000000, slots_ovr_q};

    // ------------------------------------------------------------
    // Write response
    // ------------------------------------------------------------
    axil_resp_hold #(
        .W(2)
    ) u_bresp (
        .aclk(aclk),
        .aresetn(aresetn),
        .load(do_write),
        .load_data(mapped(wr_addr) ? `RESP_OKAY : `RESP_SLVERR),
        .valid_q(bvalid_w),
        .ready(s_axi_bready),
        .data_q(s_axi_bresp)
    );
    assign s_axi_bvalid = bvalid_w;

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    assign s_axi_arready = !rvalid_w;

    always @* begin
        rd_mux = 32'h0000_0000;
        case (decode(s_axi_araddr))
            A_CAP: rd_mux = cap_word;
            A_CTRL: rd_mux = vc1_control_q;
            A_PRES: rd_mux = {31'h0000_0000, present_next_q};
            default: begin
                if ({s_axi_araddr[11:2], 2'b00} == `VC1_EEPROM_SLOTS_OFS) begin
                    rd_mux = slot_reg;
                end
            end
        endcase
    end

    axil_resp_hold #(
        .W(34)
    ) u_rresp (
        .aclk(aclk),
        .aresetn(aresetn),
        .load(s_axi_arvalid && !rvalid_w),
        .load_data({mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR,
            rd_mux}),
        .valid_q(rvalid_w),
        .ready(s_axi_rready),
        .data_q({s_axi_rresp, s_axi_rdata})
    );
    assign s_axi_rvalid = rvalid_w;

endmodule // vc1_cap_bank

// [verif/vc1_cap_bank_asserts.sv]
// Concurrent checks on the VC1 capability register bank ports
`timescale 1ns/1ps
`include "vc1_cap_regs.vh"
module vc1_cap_bank_asserts (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Read channels
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Write response
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Block state
    input wire logic vc1_present_q
);
    logic [11:0] rd_addr_q;
    logic cap_rd;
    logic [11:0] rd_word;
    logic mapped;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ------------------------------------------------------------
    // Address of the read in flight
    // ------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) rd_addr_q <= 12'h000;
        else if (s_axi_arvalid && s_axi_arready) rd_addr_q <= s_axi_araddr;
    end
    // Slave decodes whole words, so the two low address bits are ignored
    assign rd_word = {rd_addr_q[11:2], 2'b00};
    assign cap_rd = s_axi_rvalid &&
        (rd_word == `VC1_RESOURCE_CAPABILITY_OFS);
    assign mapped = rd_word == `VC1_RESOURCE_CAPABILITY_OFS ||
        rd_word == `VC1_RESOURCE_CONTROL_OFS ||
        rd_word == `VC_PRESENT_OFS || rd_word == `VC1_EEPROM_SLOTS_OFS;
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence rd_wait;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    rd_hold_a: assert property (rd_wait |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    cap_on_a: assert property (cap_rd && vc1_present_q |->
        s_axi_rdata[7:0] == 8'h19 && s_axi_rdata[31:24] == 8'h08)
        else $error("capability fields wrong with channel present");
    cap_off_a: assert property (cap_rd && !vc1_present_q
        |-> s_axi_rdata == 32'h0000_0000)
        else $error("capability not zero with channel absent");
    cap_rsvd_a: assert property (cap_rd |->
        s_axi_rdata[15:8] == 8'h00 && s_axi_rdata[23] == 1'b0)
        else $error("fixed capability bits not zero");
    present_hold_a: assert property ($past(aresetn) |->
        $stable(vc1_present_q))
        else $error("present flag moved outside reset");
    unmapped_rd_a: assert property (s_axi_rvalid && !mapped |->
        s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
endmodule // vc1_cap_bank_asserts

bind vc1_cap_bank vc1_cap_bank_asserts chk_u (.aclk(aclk),
    .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .vc1_present_q(vc1_present_q));

// [verif/testbench.sv]
// Self-checking bench for the VC1 capability register bank
`timescale 1ns/1ps
`include "vc1_cap_regs.vh"
module testbench;
    logic aclk = 0, aresetn = 0;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0;
    logic [3:0] wstrb = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    wire awready, wready, bvalid, arready, rvalid, present;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata, ctrl;
    int bad_count = 0, checks_done = 0, i, lag = 0;
    logic [31:0] d, v;
    logic [1:0] r;
    always #50 aclk = ~aclk;
    vc1_cap_bank dut_u (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .vc1_present_q(present), .vc1_control_q(ctrl));
    // ------------------------------------------------------------
    // Checking and reporting
    // ------------------------------------------------------------
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk2(input logic [1:0] got, input logic [1:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] exp_cap(input logic on, input logic ov,
        input logic [6:0] s);
        exp_cap = on ? {8'h08, 1'b0, ov ? s : 7'h7f, 8'h00, 8'h19} : 32'h0;
    endfunction
    // ------------------------------------------------------------
    // Bus tasks; handshakes are judged at the falling edge before the
    // rising edge that takes them, so no race with the design's updates
    // ------------------------------------------------------------
    task automatic timed_out;
        bad_count++;
        $display("CHECK FAILED t=%0t got %h exp %h", $time, 1'b0, 1'b1);
        summarize();
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] dd,
        input logic [3:0] s, output logic [1:0] rs);
        int n;
        logic aw_hs, w_hs, b_hs;
        awaddr <= a; wdata <= dd; wstrb <= s;
        awvalid <= 1; wvalid <= 1; bready <= (lag == 0);
        for (n = 0; n < 20; n++) begin
            // A late bready makes the slave hold its response
            if (n == lag && n != 0) bready <= 1;
            @(negedge aclk);
            aw_hs = awvalid && awready;
            w_hs = wvalid && wready;
            b_hs = bvalid && bready;
            rs = bresp;
            @(posedge aclk);
            if (aw_hs) awvalid <= 0;
            if (w_hs) wvalid <= 0;
            if (b_hs) return;
        end
        timed_out();
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] dd,
        output logic [1:0] rs);
        int n;
        logic ar_hs, r_hs;
        araddr <= a; arvalid <= 1; rready <= (lag == 0);
        for (n = 0; n < 20; n++) begin
            if (n == lag && n != 0) rready <= 1;
            @(negedge aclk);
            ar_hs = arvalid && arready;
            r_hs = rvalid && rready;
            dd = rdata;
            rs = rresp;
            @(posedge aclk);
            if (ar_hs) arvalid <= 0;
            if (r_hs) return;
        end
        timed_out();
    endtask
    task automatic rst(input int n);
        aresetn <= 0;
        repeat (n) @(posedge aclk);
        aresetn <= 1;
    endtask
    task automatic cap_is(input logic [31:0] e);
        rd(`VC1_RESOURCE_CAPABILITY_OFS, d, r);
        chk32(d, e);
        chk2(r, `RESP_OKAY);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        v = $urandom(28);
        rst(3);
        cap_is(exp_cap(0, 0, 7'h00));
        chk32({31'h0, present}, 32'h0);
        $display("test absent_reset done");
        wr(`VC_PRESENT_OFS, 32'h0000_0001, 4'h1, r);
        chk2(r, `RESP_OKAY);
        rst(1);
        cap_is(exp_cap(1, 0, 7'h00));
        chk32({31'h0, present}, 32'h1);
        $display("test present_reset done");
        for (i = 0; i < 4; i++) begin
            lag = $urandom % 4;
            wr(`VC1_RESOURCE_CAPABILITY_OFS, $urandom, 4'($urandom), r);
            chk2(r, `RESP_OKAY);
            cap_is(exp_cap(1, 0, 7'h00));
        end
        wr(`VC1_RESOURCE_CAPABILITY_OFS, 32'hffff_ffff, 4'hf, r);
        cap_is(exp_cap(1, 0, 7'h00));
        $display("test readonly_writes done");
        for (i = 0; i < 3; i++) begin
            v = {25'h0, 7'($urandom)};
            if (i == 0) v = 32'h0;
            lag = $urandom % 4;
            wr(`VC1_EEPROM_SLOTS_OFS, 32'h8000_0000 | v, 4'hf, r);
            chk2(r, `RESP_OKAY);
            cap_is(exp_cap(1, 1, v[6:0]));
        end
        $display("test slot_override done");
        d = $urandom;
        wr(`VC1_RESOURCE_CONTROL_OFS, d, 4'hf, r);
        chk2(r, `RESP_OKAY);
        rd(`VC1_RESOURCE_CONTROL_OFS, v, r);
        chk32(v, d);
        chk32(ctrl, d);
        wr(12'h004, 32'h1234_5678, 4'hf, r);
        chk2(r, `RESP_SLVERR);
        rd(12'h004, v, r);
        chk32(v, 32'h0);
        chk2(r, `RESP_SLVERR);
        $display("test control_and_unmapped done");
        rst(3);
        cap_is(exp_cap(0, 0, 7'h00));
        chk32({31'h0, present}, 32'h0);
        $display("test second_reset done");
        summarize();
    end
endmodule // testbench
